// >>> src/sched_pkg.sv
package sched_pkg;
  localparam int TAG_W        = 32;      // tag value width
  localparam int TAG_ZERO_HI  = 31;      // top zero field
  localparam int TAG_ZERO_LO  = 24;
  localparam int TAG_PORT_HI  = 23;      // port or all ones
  localparam int TAG_PORT_LO  = 16;
  localparam int TAG_HASH_HI  = 15;      // flow hash
  localparam int TAG_HASH_LO  = 0;
  localparam logic [7:0] TAG_ZERO_VAL = 8'h00;
  localparam int PTR_W        = 32;      // work pointer width

  typedef enum logic [1:0] {
    TT_ORDERED,
    TT_ATOMIC,
    TT_NULL
  } tag_type_t;

  // one work entry as it travels
  typedef struct packed {
    logic [PTR_W-1:0] ptr;               // work pointer
    tag_type_t        tt;                // tag type
    logic [TAG_W-1:0] tag;               // tag value
  } work_t;

  // ingress submission fields
  typedef struct packed {
    logic [PTR_W-1:0] ptr;               // work pointer
    tag_type_t        tt;                // first tag type
    logic [7:0]       port;              // receiving port
    logic             port_valid;        // 0: port field all ones
    logic [15:0]      hash;              // flow hash
  } ingress_t;
endpackage

// >>> src/work_scheduler.sv
`timescale 1ns/1ps
module work_scheduler #(
  parameter int DEPTH  = 16,             // entry slots
  parameter int NCORES = 4,              // requesting cores
  parameter int NQOS   = 8               // qos input queues
) (
  input  wire logic                       clk,         // 125 MHz
  input  wire logic                       resetn,      // async, low
  input  wire logic                       ce,          // clock enable
  input  wire logic                       add_valid,   // ingress offer
  output logic                            add_ready,   // slot free
  input  wire sched_pkg::ingress_t        add_data,    // ingress entry
  input  wire logic [$clog2(NQOS)-1:0]    add_qos,     // 0 = highest
  input  wire logic [NCORES-1:0]          get_req,     // work request
  output logic [NCORES-1:0]               get_ack,     // request done
  output logic [NCORES-1:0]               get_hit,     // entry given
  output sched_pkg::work_t                get_data,    // given entry
  input  wire logic [NCORES-1:0]          sw_req,      // tag switch
  input  wire sched_pkg::tag_type_t       sw_tt,       // new type
  input  wire logic [sched_pkg::TAG_W-1:0] sw_tag,     // new value
  input  wire logic [NCORES-1:0]          done_req,    // release entry
  output logic [NCORES-1:0]               lock_grant,  // grant pulse
  output logic [NCORES-1:0]               lock_pend    // wait status
);
  import sched_pkg::*;

  localparam int IW = $clog2(DEPTH);
  localparam int CW = (NCORES > 1) ? $clog2(NCORES) : 1;
  localparam int QW = $clog2(NQOS);
  localparam int SW = IW + 2;            // ingress sequence width

  // per-slot storage
  logic            used    [DEPTH];      // slot occupied
  logic            owned   [DEPTH];      // assigned to a core
  logic            held    [DEPTH];      // atomic lock held
  logic            pend    [DEPTH];      // awaiting atomic grant
  logic [QW-1:0]   qos     [DEPTH];      // input queue
  logic [SW-1:0]   seq     [DEPTH];      // ingress sequence
  logic [CW-1:0]   core_of [DEPTH];      // owning core
  work_t           ent     [DEPTH];      // entry contents
  logic [SW-1:0]   seq_ctr;              // next ingress number
  logic [NCORES-1:0] busy;               // core holds an entry
  logic [IW-1:0]   slot_of [NCORES];     // entry of each core
  // ordered tag that a pending switch left; kept so the switch still
  // queues behind older members of the flow it is leaving
  logic [TAG_W-1:0] from_tag [DEPTH];    // tag before the switch
  logic            from_ord [DEPTH];     // switch came from ordered

  logic            next_used    [DEPTH];
  logic            next_owned   [DEPTH];
  logic            next_held    [DEPTH];
  logic            next_pend    [DEPTH];
  logic [QW-1:0]   next_qos     [DEPTH];
  logic [SW-1:0]   next_seq     [DEPTH];
  logic [CW-1:0]   next_core_of [DEPTH];
  work_t           next_ent     [DEPTH];
  logic [SW-1:0]   next_seq_ctr;
  logic [NCORES-1:0] next_busy;
  logic [IW-1:0]   next_slot_of [NCORES];
  logic [TAG_W-1:0] next_from_tag [DEPTH];
  logic            next_from_ord [DEPTH];
  logic [NCORES-1:0] next_get_ack, next_get_hit, next_grant;
  work_t           next_get_data;

  // wrap-safe ingress age compare: a older than b
  function automatic logic older(input logic [SW-1:0] a,
                                 input logic [SW-1:0] b);
    logic [SW-1:0] d;
    d = a - b;
    return d[SW-1];
  endfunction

  // same tag tuple
  function automatic logic same_tuple(input work_t a, input work_t b);
    return (a.tt == b.tt) && (a.tag == b.tag);
  endfunction

  // first tag built at ingress
  function automatic logic [TAG_W-1:0] first_tag(input ingress_t d);
    logic [TAG_W-1:0] t;
    t = '0;
    t[TAG_ZERO_HI:TAG_ZERO_LO] = TAG_ZERO_VAL;
    t[TAG_PORT_HI:TAG_PORT_LO] = d.port_valid ? d.port : 8'hFF;
    t[TAG_HASH_HI:TAG_HASH_LO] = d.hash;
    return t;
  endfunction

  // atomic slot i is blocked while an older or held same-tuple atomic
  // entry exists; computed from registered state only
  function automatic logic blocked(input int i);
    logic b;
    b = 1'b0;
    for (int j = 0; j < DEPTH; j++)
    begin
      if (j != i && used[j] && ent[j].tt == TT_ATOMIC &&
          same_tuple(ent[j], ent[i]) &&
          (held[j] || older(seq[j], seq[i])))
        b = 1'b1;
      // leaving an ordered flow: wait for older members still in it,
      // whether they stayed ordered or are themselves waiting to leave
      if (j != i && used[j] && from_ord[i] && older(seq[j], seq[i]) &&
          ((ent[j].tt == TT_ORDERED && ent[j].tag == from_tag[i]) ||
           (pend[j] && from_ord[j] && from_tag[j] == from_tag[i])))
        b = 1'b1;
    end
    return b;
  endfunction

  // free slot search
  logic          free_hit;
  logic [IW-1:0] free_idx;
  always_comb
  begin
    free_hit = 1'b0;
    free_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (!used[i])
      begin
        free_hit = 1'b1;
        free_idx = IW'(i);
      end
    end
  end

  // backpressure only when no slot is free
  assign add_ready = free_hit;

  // next-state for the whole entry table
  always_comb
  begin
    logic          take;
    logic          pick_hit;
    logic [IW-1:0] pick;
    logic [QW-1:0] best_q;
    logic [SW-1:0] best_s;
    logic [CW-1:0] c;
    int            s;
    next_used     = used;
    next_owned    = owned;
    next_held     = held;
    next_pend     = pend;
    next_qos      = qos;
    next_seq      = seq;
    next_core_of  = core_of;
    next_ent      = ent;
    next_seq_ctr  = seq_ctr;
    next_busy     = busy;
    next_slot_of  = slot_of;
    next_from_tag = from_tag;
    next_from_ord = from_ord;
    next_get_ack  = '0;
    next_get_hit  = '0;
    next_grant    = '0;
    next_get_data = get_data;
    take     = 1'b0;
    pick_hit = 1'b0;
    pick     = '0;
    best_q   = '0;
    best_s   = '0;
    c        = '0;
    s        = 0;

    // ingress: new entry into chosen queue with first tag
    if (add_valid && free_hit)
    begin
      next_used[free_idx]    = 1'b1;
      next_owned[free_idx]   = 1'b0;
      next_held[free_idx]    = 1'b0;
      next_pend[free_idx]    = 1'b0;
      next_from_ord[free_idx] = 1'b0;
      next_qos[free_idx]     = add_qos;
      next_seq[free_idx]     = seq_ctr;
      next_ent[free_idx].ptr = add_data.ptr;
      next_ent[free_idx].tt  = add_data.tt;
      next_ent[free_idx].tag = first_tag(add_data);
      next_seq_ctr           = seq_ctr + 1'b1;
    end

    // one core per cycle, lowest index first
    for (int k = 0; k < NCORES; k++)
    begin
      if (!take && get_req[k] && !busy[k])
      begin
        take = 1'b1;
        c    = CW'(k);
      end
    end

    // pick: lowest qos number, then oldest, skipping blocked atomics
    for (int i = 0; i < DEPTH; i++)
    begin
      if (used[i] && !owned[i] &&
          !(ent[i].tt == TT_ATOMIC && blocked(i)))
      begin
        if (!pick_hit || qos[i] < best_q ||
            (qos[i] == best_q && older(seq[i], best_s)))
        begin
          pick_hit = 1'b1;
          pick     = IW'(i);
          best_q   = qos[i];
          best_s   = seq[i];
        end
      end
    end

    // hand out work; an atomic entry arrives already holding its lock
    if (take)
    begin
      next_get_ack[c] = 1'b1;
      if (pick_hit)
      begin
        next_get_hit[c]     = 1'b1;
        next_get_data       = ent[pick];
        next_owned[pick]    = 1'b1;
        next_core_of[pick]  = c;
        next_held[pick]     = (ent[pick].tt == TT_ATOMIC);
        next_busy[c]        = 1'b1;
        next_slot_of[c]     = pick;
      end
    end

    // per-core tag switch or release of its own entry
    for (int k = 0; k < NCORES; k++)
    begin
      s = int'(slot_of[k]);
      if (busy[k] && done_req[k])
      begin
        next_used[s]  = 1'b0;        // frees lock and ordering slot
        next_held[s]  = 1'b0;
        next_pend[s]  = 1'b0;
        next_busy[k]  = 1'b0;
      end
      else if (busy[k] && sw_req[k] && !pend[s])
      begin
        next_ent[s].tt  = sw_tt;
        next_ent[s].tag = sw_tag;
        next_held[s]    = 1'b0;
        // atomic requests wait; entry stays with its core
        next_pend[s]    = (sw_tt == TT_ATOMIC);
        // remember the ordered flow being left, for its ingress order
        next_from_ord[s] = (ent[s].tt == TT_ORDERED) &&
                           (sw_tt == TT_ATOMIC);
        next_from_tag[s] = ent[s].tag;
        // keeps original ingress number so order survives switches
      end
    end

    // grant waiting atomic switches oldest-first per tuple
    for (int i = 0; i < DEPTH; i++)
    begin
      if (used[i] && pend[i] && !blocked(i) &&
          next_used[i] && next_pend[i])
      begin
        next_pend[i] = 1'b0;
        next_from_ord[i] = 1'b0;     // has left the ordered flow
        next_held[i] = 1'b1;
        next_grant[core_of[i]] = 1'b1;
      end
    end
  end

  // register the table
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        used[i]    <= 1'b0;
        owned[i]   <= 1'b0;
        held[i]    <= 1'b0;
        pend[i]    <= 1'b0;
        qos[i]     <= '0;
        seq[i]     <= '0;
        core_of[i] <= '0;
        ent[i]     <= '0;
        from_tag[i] <= '0;
        from_ord[i] <= 1'b0;
      end
      for (int k = 0; k < NCORES; k++)
        slot_of[k] <= '0;
      seq_ctr    <= '0;
      busy       <= '0;
      get_ack    <= '0;
      get_hit    <= '0;
      get_data   <= '0;
      lock_grant <= '0;
    end
    else if (ce)
    begin
      used     <= next_used;
      owned    <= next_owned;
      held     <= next_held;
      pend     <= next_pend;
      qos      <= next_qos;
      seq      <= next_seq;
      core_of  <= next_core_of;
      ent      <= next_ent;
      from_tag <= next_from_tag;
      from_ord <= next_from_ord;
      slot_of  <= next_slot_of;
      seq_ctr  <= next_seq_ctr;
      busy     <= next_busy;
      get_ack  <= next_get_ack;
      get_hit  <= next_get_hit;
      get_data <= next_get_data;
      lock_grant <= next_grant;
    end
  end

  // pollable wait status per core, null/ordered never wait
  always_comb
  begin
    for (int k = 0; k < NCORES; k++)
      lock_pend[k] = busy[k] && pend[slot_of[k]];
  end
  // different tuples block only when an atomic switch leaves an ordered flow; ordered/null entries are never blocked
  // null entries are never checked by the blocking search
  // tuple compare covers type and value
endmodule

// >>> verification/sched_props.sv
`timescale 1ns/1ps
module sched_props
  import sched_pkg::*;
#(
  parameter int NCORES = 4
) (
  input wire logic              clk,        // core clock
  input wire logic              resetn,     // async reset
  input wire logic [NCORES-1:0] get_req,    // work request
  input wire logic [NCORES-1:0] get_ack,    // request done
  input wire logic [NCORES-1:0] get_hit,    // entry given
  input wire work_t             get_data,   // given entry
  input wire logic [NCORES-1:0] sw_req,     // tag switch
  input wire logic [NCORES-1:0] lock_grant, // grant pulse
  input wire logic [NCORES-1:0] lock_pend   // wait status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // a hit never stands alone
  AST_HIT_ACK: assert property ((get_hit & ~get_ack) == '0)
    else $error("hit without ack");
  AST_ACK_ONE: assert property ($onehot0(get_ack))
    else $error("two acks in one cycle");
  AST_ACK_REQ: assert property ((get_ack & ~$past(get_req)) == '0)
    else $error("ack without request");
  AST_DATA_HOLD: assert property (get_hit == '0 |-> $stable(get_data))
    else $error("entry moved without hit");
  AST_TT_LEGAL: assert property
    (get_hit != '0 |-> get_data.tt inside {TT_ORDERED, TT_ATOMIC, TT_NULL})
    else $error("illegal tag type");
  // waiting only starts from a switch
  AST_PEND_CAUSE: assert property
    ((lock_pend & ~$past(lock_pend) & ~$past(sw_req)) == '0)
    else $error("pend without switch");
  AST_GRANT_CAUSE: assert property
    ((lock_grant & ~$past(lock_pend | sw_req)) == '0)
    else $error("grant without request");
  AST_GRANT_PEND: assert property ((lock_grant & lock_pend) == '0)
    else $error("grant while still pending");
  AST_GRANT_PULSE: assert property
    ((lock_grant & $past(lock_grant)) == '0)
    else $error("grant longer than a pulse");
  COV_HIT: cover property (get_hit != '0);
  COV_MISS: cover property (get_ack != '0 && get_hit == '0);
  COV_WAIT: cover property ((lock_pend != '0) ##[1:20] (lock_grant != '0));
endmodule

// >>> verification/core_model.sv
`timescale 1ns/1ps
module core_model #(
  parameter int NCORES = 4
) (
  input wire logic              clk,     // core clock
  input wire logic [NCORES-1:0] go,      // bench wants work
  output logic [NCORES-1:0]     get_req  // one-cycle request
);
  // one request per go, so a core never holds two entries
  initial get_req = '0;
  always @(posedge clk)
    get_req <= #1 go;
endmodule

// >>> verification/work_scheduler_test.sv
`timescale 1ns/1ps
module work_scheduler_test;
  import sched_pkg::*;
  typedef struct { int qos; work_t w; } entry_t; // model slot
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       ce = 1'b1;   // clock enable, dropped in one scenario
  logic       add_valid = 1'b0;
  logic       add_ready;
  ingress_t   add_data = '0;
  logic [2:0] add_qos = '0;
  logic [3:0] go = '0, sw_req = '0, done_req = '0;
  logic [3:0] get_req, get_ack, get_hit, lock_grant, lock_pend;
  tag_type_t  sw_tt = TT_NULL;
  logic [31:0] sw_tag = '0;
  work_t      get_data;
  entry_t     model[$];   // pending entries, in ingress order
  int         fail_count = 0;
  int         checked = 0;
  ingress_t   e;
  int         q;
  always #4 clk = ~clk;
  work_scheduler i_work_scheduler (.clk(clk), .resetn(resetn), .ce(ce),
    .add_valid(add_valid), .add_ready(add_ready), .add_data(add_data),
    .add_qos(add_qos), .get_req(get_req), .get_ack(get_ack),
    .get_hit(get_hit), .get_data(get_data), .sw_req(sw_req), .sw_tt(sw_tt),
    .sw_tag(sw_tag), .done_req(done_req), .lock_grant(lock_grant),
    .lock_pend(lock_pend));
  core_model i_core_model (.clk(clk), .go(go), .get_req(get_req));
  task check_bit(logic got, logic exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task check_work(work_t got, work_t exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t entry %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // offer until taken, then remember the expected tag layout
  task add(ingress_t d, int qs);
    add_valid = 1'b1;
    add_data = d;
    add_qos = qs[2:0];
    while (add_ready !== 1'b1) tick;
    tick;
    add_valid = 1'b0;
    // one idle edge, so a following offer never re-raises valid at once
    tick;
    model.push_back('{qs, '{d.ptr, d.tt,
      {8'h00, d.port_valid ? d.port : 8'hFF, d.hash}}});
  endtask
  // model picks lowest qos, oldest first among equals
  task get(int k, logic hit);
    int b;
    b = 0;
    go[k] = 1'b1;
    tick;
    go[k] = 1'b0;
    for (int i = 0; i < 20 && get_ack[k] !== 1'b1; i++) tick;
    check_bit(get_ack[k], 1'b1);
    check_bit(get_hit[k], hit);
    if (hit)
    begin
      foreach (model[i]) if (model[i].qos < model[b].qos) b = i;
      check_work(get_data, model[b].w);
      model.delete(b);
    end
  endtask
  task done(int k);
    done_req[k] = 1'b1;
    tick;
    done_req[k] = 1'b0;
  endtask
  task sw(int k, tag_type_t t, logic [31:0] v);
    sw_req[k] = 1'b1;
    sw_tt = t;
    sw_tag = v;
    tick;
    sw_req[k] = 1'b0;
  endtask
  task wait_grant(int k);
    for (int i = 0; i < 20 && lock_grant[k] !== 1'b1; i++) tick;
    check_bit(lock_grant[k], 1'b1);
  endtask
  initial
  begin
    void'($urandom(32'h83F9));
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    tick;
    // three tag types, shuffled priorities
    q = $urandom % 6;
    for (int i = 0; i < 3; i++)
    begin
      e = ingress_t'({$urandom, 2'(i), 8'($urandom), 1'($urandom),
        16'($urandom)});
      add(e, q + (i + 1) % 3);
    end
    for (int i = 0; i < 3; i++)
    begin
      get(0, 1'b1);
      done(0);
    end
    get(0, 1'b0);
    // same atomic tuple twice: second waits for the first
    e = ingress_t'({32'h1000, TT_ATOMIC, 8'h07, 1'b1, 16'hBEEF});
    add(e, 1);
    e.ptr = 32'h1001;
    add(e, 1);
    get(0, 1'b1);
    get(1, 1'b0);
    done(0);
    get(1, 1'b1);
    done(1);
    // ordered pair of one flow, both switch into one lock
    e = ingress_t'({32'h2000, TT_ORDERED, 8'h03, 1'b1, 16'h55AA});
    add(e, 0);
    e.ptr = 32'h2001;
    add(e, 0);
    get(0, 1'b1);
    get(1, 1'b1);
    sw(0, TT_ATOMIC, 32'h00AB_0001);
    wait_grant(0);
    sw(1, TT_ATOMIC, 32'h00AB_0001);
    repeat (3) tick;
    check_bit(lock_pend[1], 1'b1);
    done(0);
    wait_grant(1);
    check_bit(lock_pend[1], 1'b0);
    done(1);
    // younger switches first; the older one must still lock first
    e = ingress_t'({32'h3000, TT_ORDERED, 8'h05, 1'b1, 16'h1234});
    add(e, 0);
    e.ptr = 32'h3001;
    add(e, 0);
    get(0, 1'b1);
    get(1, 1'b1);
    sw(1, TT_ATOMIC, 32'h00CD_0002);
    repeat (3) tick;
    check_bit(lock_pend[1], 1'b1);
    check_bit(lock_grant[1], 1'b0);
    sw(0, TT_ATOMIC, 32'h00CD_0002);
    wait_grant(0);
    check_bit(lock_pend[1], 1'b1);
    tick;
    // frozen: a release is not seen and the waiter stays put
    ce = 1'b0;
    done(0);
    repeat (3) tick;
    check_bit(lock_grant[1], 1'b0);
    check_bit(lock_pend[1], 1'b1);
    ce = 1'b1;
    done(0);
    wait_grant(1);
    check_bit(lock_pend[1], 1'b0);
    done(1);
    // fill every slot: ingress must stall, then drain oldest first
    for (int i = 0; i < 16; i++)
    begin
      e = ingress_t'({32'h4000 + 32'(i), TT_NULL, 8'($urandom), 1'b0,
        16'($urandom)});
      add(e, 7);
    end
    check_bit(add_ready, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      get(2, 1'b1);
      done(2);
    end
    check_bit(add_ready, 1'b1);
    finish_test;
  end
  initial
  begin
    #20000;
    fail_count++;
    finish_test;
  end
endmodule
bind work_scheduler sched_props #(.NCORES(NCORES)) i_sched_props (
  .clk(clk), .resetn(resetn), .get_req(get_req), .get_ack(get_ack),
  .get_hit(get_hit), .get_data(get_data), .sw_req(sw_req),
  .lock_grant(lock_grant), .lock_pend(lock_pend));
